//--- verilog/ocd_pkg.sv
// Purpose: Shared constants of the output clock divider block
// Assumes: Byte-wide register port, 12-bit byte addresses
// Notes:   Offsets are byte addresses of one output's register group
package ocd_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] OCD_OFS_CFG1   = 12'h200;
  localparam logic [11:0] OCD_OFS_CFG2   = 12'h201;
  localparam logic [11:0] OCD_OFS_CFG3   = 12'h202;
  localparam logic [11:0] OCD_OFS_LDIV0  = 12'h203;
  localparam logic [11:0] OCD_OFS_LDIV1  = 12'h204;
  localparam logic [11:0] OCD_OFS_LDIV2  = 12'h205;
  localparam logic [11:0] OCD_OFS_DUTY   = 12'h206;
  localparam logic [11:0] OCD_OFS_PHASE  = 12'h207;
  localparam logic [11:0] OCD_OFS_CTRL   = 12'h208;
  localparam logic [11:0] OCD_OFS_STATUS = 12'h209;
  localparam logic [7:0]  OCD_RST_BYTE   = 8'h00;
  localparam logic [7:0]  OCD_RST_CTRL   = 8'h40;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int OCD_B_PHASE_ALIGN_ENABLE    = 7;
  localparam int OCD_B_SQUELCH = 7;
  localparam int OCD_B_INVERT  = 6;
  localparam int OCD_B_DRIVE   = 4;
  localparam int OCD_B_TRIST   = 3;
  localparam int OCD_B_STSEN   = 7;
  localparam int OCD_B_FAST_DIVIDER_SELECT  = 6;
  localparam int OCD_B_NEG_PIN_LOW_DIV_SOURCE  = 5;
  localparam int OCD_B_LOW_DIV_OUTPUT_SELECT   = 4;
  localparam int OCD_B_LDIV24  = 0;
  localparam int OCD_B_STOP    = 7;
  localparam int OCD_B_GOE     = 6;
  localparam int OCD_B_LOW_DIV_CLOCK_LATCHED  = 1;

  localparam int OCD_MID_W = 7;
  localparam int OCD_LOW_W = 25;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OCD_FMT_OFF    = 3'h0,
    OCD_FMT_CML    = 3'h1,
    OCD_FMT_CML_N  = 3'h2,
    OCD_FMT_HSTL   = 3'h3,
    OCD_FMT_CMOS2  = 3'h4,
    OCD_FMT_CMOS_N = 3'h5,
    OCD_FMT_CMOS_P = 3'h6,
    OCD_FMT_CMOS2I = 3'h7
  } ocd_fmt_e;

  typedef enum logic [1:0] {
    OCD_STOP_NEVER = 2'h0,
    OCD_STOP_HIGH  = 2'h1,
    OCD_STOP_LOW   = 2'h2,
    OCD_STOP_RSVD  = 2'h3
  } ocd_stop_mode_e;

  typedef enum logic {
    OCD_ST_RUN  = 1'b0,
    OCD_ST_HELD = 1'b1
  } ocd_state_e;
endpackage : ocd_pkg

//--- verilog/ocd_counter.sv
// Purpose: Wrapping divider counter, divides its enable rate by limit+1
// Assumes: limit may change at any time; count restarts at zero on wrap
// Notes:   wrap_q pulses for one cycle, in the same cycle the count returns to zero
`timescale 1ns/1ns
`default_nettype none
module ocd_counter #(
  parameter int W = 7
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         en,
  input  wire logic [W-1:0] limit,
  output logic      [W-1:0] count_q,
  output logic              wrap_q
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
      wrap_q  <= 1'b0;
    end else begin
      wrap_q <= 1'b0;
      if (en) begin
        // Limit lowered below count: wrap now, not at overflow
        if (count_q >= limit) begin
          count_q <= '0;
          wrap_q  <= 1'b1;
        end else begin
          count_q <= count_q + 1'b1;
        end
      end
    end
  end
endmodule : ocd_counter
`default_nettype wire

//--- verilog/ocd_output_divider.sv
// Purpose: One output's clock path: fast divider select, mid and low dividers,
//          duty shaping, start/stop, squelch, invert and pin format control
// Assumes: Fast divider clocks arrive as levels synchronous to clk
// Notes:   Phase steps resolve to whole fast periods; half steps are dropped
//
// Behaviour
// - Phase align enable gates phase adjust events for this output.
// - Mid divider divides the selected fast clock by value plus one.
// - Mid value zero bypasses all dividers, edge-aligned stop and duty to the driver.
// - Auto squelch stops output without reference; modes 01/10 squelch at edge.
// - Squelched CML or complementary CMOS keeps negative pin opposite positive.
// - Invert flips CML, HSTL and CMOS path, never negative low divider path.
// - Drive field 00..11 enables one to four driver sections.
// - Stopped output tristate bit floats pins while the clock is stopped.
// - Format select codes: off, CML, narrow CML, HSTL, four CMOS kinds.
// - Global output enable zero floats the driver for any format.
// - Low divider status enable gates live and latched status; else reads low.
// - Fast divider select picks first divider at 0, second at 1.
// - CMOS negative pin follows low divider at 1 if mid nonzero, positive clock at 0.
// - Low output select picks low divider over mid; honoured only if mid nonzero.
// - Low divider divides mid clock by 25-bit value plus one; needs mid nonzero.
// - Pulse count zero, or low value under 2, gives 50%; else pulse of that many mid periods.
// - Pulse is high without invert, low with invert.
// - Stop mode 01 holds high, 10 holds low, 00 stops low at once.
// - Phase step is signed half fast periods; positive delays the output.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module ocd_output_divider
  import ocd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  input  wire logic        fast_divider_one,
  input  wire logic        fast_divider_two,
  input  wire logic        selected_reference,
  input  wire logic        phase_adjust_event,
  output logic             pos_output_pin,
  output logic             pos_output_oe,
  output logic             neg_output_pin,
  output logic             neg_output_oe,
  output logic      [3:0]  drive_section_enable,
  output logic      [2:0]  signal_format_select
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] cfg1_q, cfg2_q, cfg3_q, ldiv0_q, ldiv1_q, ldiv2_q;
  logic [7:0] duty_q, phase_q, ctrl_q;
  logic       low_div_clock_status_latched_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg1_q  <= OCD_RST_BYTE;
      cfg2_q  <= OCD_RST_BYTE;
      cfg3_q  <= OCD_RST_BYTE;
      ldiv0_q <= OCD_RST_BYTE;
      ldiv1_q <= OCD_RST_BYTE;
      ldiv2_q <= OCD_RST_BYTE;
      duty_q  <= OCD_RST_BYTE;
      phase_q <= OCD_RST_BYTE;
      ctrl_q  <= OCD_RST_CTRL;
    end else if (reg_write) begin
      case (reg_addr)
        OCD_OFS_CFG1:  cfg1_q  <= reg_wdata;
        OCD_OFS_CFG2:  cfg2_q  <= reg_wdata;
        OCD_OFS_CFG3:  cfg3_q  <= reg_wdata & 8'hf1;
        OCD_OFS_LDIV0: ldiv0_q <= reg_wdata;
        OCD_OFS_LDIV1: ldiv1_q <= reg_wdata;
        OCD_OFS_LDIV2: ldiv2_q <= reg_wdata;
        OCD_OFS_DUTY:  duty_q  <= reg_wdata;
        OCD_OFS_PHASE: phase_q <= reg_wdata;
        OCD_OFS_CTRL:  ctrl_q  <= reg_wdata & 8'hc3;
        default: ;
      endcase
    end
  end

  // Field views
  logic                 phase_align_enable, auto_squelch_enable, clock_path_invert;
  logic                 stopped_output_tristate, low_div_status_enable;
  logic                 fast_divider_select, neg_pin_low_div_source;
  logic                 low_div_output_select, stop_request, global_output_enable;
  logic [OCD_MID_W-1:0] mid_divider_value;
  logic [OCD_LOW_W-1:0] low_divider_value;
  logic [7:0]           pulse_width_count;
  logic signed [7:0]    phase_step_value;
  logic [2:0]           fmt;
  logic [1:0]           stop_mode;
  logic                 mid_on;

  assign phase_align_enable      = cfg1_q[OCD_B_PHASE_ALIGN_ENABLE];
  assign mid_divider_value       = cfg1_q[OCD_MID_W-1:0];
  assign auto_squelch_enable     = cfg2_q[OCD_B_SQUELCH];
  assign clock_path_invert       = cfg2_q[OCD_B_INVERT];
  assign stopped_output_tristate = cfg2_q[OCD_B_TRIST];
  assign fmt                     = cfg2_q[2:0];
  assign low_div_status_enable   = cfg3_q[OCD_B_STSEN];
  assign fast_divider_select     = cfg3_q[OCD_B_FAST_DIVIDER_SELECT];
  assign neg_pin_low_div_source  = cfg3_q[OCD_B_NEG_PIN_LOW_DIV_SOURCE];
  assign low_div_output_select   = cfg3_q[OCD_B_LOW_DIV_OUTPUT_SELECT];
  assign low_divider_value       = {cfg3_q[OCD_B_LDIV24], ldiv2_q, ldiv1_q, ldiv0_q};
  assign pulse_width_count       = duty_q;
  assign phase_step_value        = phase_q;
  assign stop_request            = ctrl_q[OCD_B_STOP];
  assign global_output_enable    = ctrl_q[OCD_B_GOE];
  assign stop_mode               = ctrl_q[1:0];
  assign mid_on                  = (mid_divider_value != '0);

  // ----------------------------------------------------------------
  // Fast clock select and edge detect
  // ----------------------------------------------------------------
  logic fast_q, fast_prev_q, fast_tick;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_q      <= 1'b0;
      fast_prev_q <= 1'b0;
    end else begin
      fast_q      <= fast_divider_select ? fast_divider_two : fast_divider_one;
      fast_prev_q <= fast_q;
    end
  end
  assign fast_tick = fast_q & ~fast_prev_q;

  // ----------------------------------------------------------------
  // Phase adjust: pending whole fast periods, sign gives direction
  // ----------------------------------------------------------------
  logic signed [6:0] phase_pend_q;
  logic              mid_en;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_pend_q <= '0;
    end else if (phase_adjust_event && phase_align_enable && mid_on) begin
      phase_pend_q <= phase_step_value[7:1];
    end else if (phase_pend_q > 0 && fast_tick) begin
      phase_pend_q <= phase_pend_q - 7'sd1;
    end else if (phase_pend_q < 0 && !fast_tick) begin
      phase_pend_q <= phase_pend_q + 7'sd1;
    end
  end

  // Positive steps swallow fast edges (delay); negative ones insert extra counts
  assign mid_en = (fast_tick && phase_pend_q <= 0) || (!fast_tick && phase_pend_q < 0);

  // ----------------------------------------------------------------
  // Mid and low dividers
  // ----------------------------------------------------------------
  logic [OCD_MID_W-1:0] mid_cnt;
  logic [OCD_LOW_W-1:0] low_cnt;
  logic                 mid_wrap, low_wrap, mid_level, low_level;

  ocd_counter #(.W(OCD_MID_W)) u_mid (
    .clk     (clk),
    .rst_n   (rst_n),
    .en      (mid_en && mid_on),
    .limit   (mid_divider_value),
    .count_q (mid_cnt),
    .wrap_q  (mid_wrap)
  );

  ocd_counter #(.W(OCD_LOW_W)) u_low (
    .clk     (clk),
    .rst_n   (rst_n),
    .en      (mid_wrap && mid_on),
    .limit   (low_divider_value),
    .count_q (low_cnt),
    .wrap_q  (low_wrap)
  );

  function automatic logic first_half(input logic [31:0] cnt, input logic [31:0] lim);
    first_half = cnt < ((lim + 32'd2) >> 1);
  endfunction : first_half

  assign mid_level = first_half(32'(mid_cnt), 32'(mid_divider_value));

  always_comb begin
    if (low_divider_value == '0) begin
      low_level = mid_level;
    end else if (pulse_width_count != 8'h00 && low_divider_value > 25'd1) begin
      low_level = low_cnt < 25'(pulse_width_count);
    end else begin
      low_level = first_half(32'(low_cnt), 32'(low_divider_value));
    end
  end

  // ----------------------------------------------------------------
  // Core clock, squelch and start/stop
  // ----------------------------------------------------------------
  logic       core, core_prev_q, want_stop, squelch, edge_stop;
  logic       held_level_q;
  ocd_state_e state_q;

  always_comb begin
    if (!mid_on) begin
      core = fast_q;
    end else if (low_div_output_select) begin
      core = low_level;
    end else begin
      core = mid_level;
    end
  end

  assign squelch   = auto_squelch_enable && !selected_reference;
  assign want_stop = stop_request || squelch;
  assign edge_stop = mid_on && (stop_mode == OCD_STOP_HIGH || stop_mode == OCD_STOP_LOW);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_prev_q <= 1'b0;
    end else begin
      core_prev_q <= core;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q      <= OCD_ST_RUN;
      held_level_q <= 1'b0;
    end else begin
      case (state_q)
        OCD_ST_RUN: begin
          if (want_stop && edge_stop) begin
            if (stop_mode == OCD_STOP_HIGH && core && !core_prev_q) begin
              state_q      <= OCD_ST_HELD;
              held_level_q <= 1'b1;
            end else if (stop_mode == OCD_STOP_LOW && !core && core_prev_q) begin
              state_q      <= OCD_ST_HELD;
              held_level_q <= 1'b0;
            end
          end
        end
        OCD_ST_HELD: begin
          if (!edge_stop) begin
            state_q <= OCD_ST_RUN;
          end else if (!want_stop) begin
            // Restart on the opposite edge so no runt pulse is emitted
            if (held_level_q && !core && core_prev_q) begin
              state_q <= OCD_ST_RUN;
            end else if (!held_level_q && core && !core_prev_q) begin
              state_q <= OCD_ST_RUN;
            end
          end
        end
        default: state_q <= OCD_ST_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin formatting
  // ----------------------------------------------------------------
  logic stopped, shaped, pol_clk, p_d, n_d, p_oe_d, n_oe_d, float_all, neg_low;

  // Squelch without edge-aligned mode, or in bypass, forces low at once
  assign stopped   = (state_q == OCD_ST_HELD) || (want_stop && !edge_stop);
  assign shaped    = (state_q == OCD_ST_HELD) ? held_level_q : (stopped ? 1'b0 : core);
  assign pol_clk   = shaped ^ clock_path_invert;
  assign float_all = !global_output_enable || fmt == OCD_FMT_OFF
                     || (stopped && stopped_output_tristate);
  assign neg_low   = neg_pin_low_div_source && mid_on && fmt[2];

  always_comb begin
    p_d    = pol_clk;
    n_d    = ~pol_clk;
    p_oe_d = 1'b1;
    n_oe_d = 1'b1;
    case (fmt)
      OCD_FMT_CML, OCD_FMT_CML_N: begin
        p_d = pol_clk;
        n_d = ~pol_clk;
      end
      OCD_FMT_HSTL, OCD_FMT_CMOS2I: begin
        n_d = pol_clk;
        p_d = ~pol_clk;
      end
      OCD_FMT_CMOS2: begin
        n_d = pol_clk;
      end
      OCD_FMT_CMOS_N: begin
        n_d    = pol_clk;
        p_oe_d = 1'b0;
      end
      OCD_FMT_CMOS_P: begin
        n_oe_d = 1'b0;
      end
      default: begin
        p_oe_d = 1'b0;
        n_oe_d = 1'b0;
      end
    endcase
    if (neg_low) begin
      n_d = low_level;
    end
    if (float_all) begin
      p_oe_d = 1'b0;
      n_oe_d = 1'b0;
    end
  end

  function automatic logic [3:0] drive_sections(input logic [1:0] code);
    case (code)
      2'h0:    drive_sections = 4'h1;
      2'h1:    drive_sections = 4'h3;
      2'h2:    drive_sections = 4'h7;
      default: drive_sections = 4'hf;
    endcase
  endfunction : drive_sections

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_output_pin       <= 1'b0;
      neg_output_pin       <= 1'b0;
      pos_output_oe        <= 1'b0;
      neg_output_oe        <= 1'b0;
      drive_section_enable <= 4'h1;
      signal_format_select <= 3'h0;
    end else begin
      pos_output_pin       <= p_d;
      neg_output_pin       <= n_d;
      pos_output_oe        <= p_oe_d;
      neg_output_oe        <= n_oe_d;
      drive_section_enable <= drive_sections(cfg2_q[OCD_B_DRIVE+:2]);
      signal_format_select <= fmt;
    end
  end

  // ----------------------------------------------------------------
  // Status and read back
  // ----------------------------------------------------------------
  logic low_div_clock_status_live, clr_latched;

  assign low_div_clock_status_live  = low_div_status_enable && mid_on && low_level;
  assign clr_latched = reg_write && reg_addr == OCD_OFS_STATUS && reg_wdata[OCD_B_LOW_DIV_CLOCK_LATCHED];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_div_clock_status_latched_q <= 1'b0;
    end else if (!low_div_status_enable) begin
      low_div_clock_status_latched_q <= 1'b0;
    end else if (low_wrap && mid_on) begin
      low_div_clock_status_latched_q <= 1'b1; // Set wins over a clear in the same cycle
    end else if (clr_latched) begin
      low_div_clock_status_latched_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        OCD_OFS_CFG1:   reg_rdata <= cfg1_q;
        OCD_OFS_CFG2:   reg_rdata <= cfg2_q;
        OCD_OFS_CFG3:   reg_rdata <= cfg3_q;
        OCD_OFS_LDIV0:  reg_rdata <= ldiv0_q;
        OCD_OFS_LDIV1:  reg_rdata <= ldiv1_q;
        OCD_OFS_LDIV2:  reg_rdata <= ldiv2_q;
        OCD_OFS_DUTY:   reg_rdata <= duty_q;
        OCD_OFS_PHASE:  reg_rdata <= phase_q;
        OCD_OFS_CTRL:   reg_rdata <= {ctrl_q[7:6], selected_reference, 3'h0, ctrl_q[1:0]};
        OCD_OFS_STATUS: reg_rdata <= {5'h00, stopped, low_div_clock_status_latched_q, low_div_clock_status_live};
        default:        reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule : ocd_output_divider
`default_nettype wire

//--- bench/ocd_output_divider_properties.sv
// Purpose: Port-level properties of the output divider block
// Assumes: Shadows update at the design's write edge
// Notes:   Repetitions cover the output register stage
`timescale 1ns/1ns
`default_nettype none
module ocd_output_divider_properties
  import ocd_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [7:0]  reg_rdata,
  input wire logic        fast_divider_one,
  input wire logic        fast_divider_two,
  input wire logic        selected_reference,
  input wire logic        pos_output_pin,
  input wire logic        pos_output_oe,
  input wire logic        neg_output_pin,
  input wire logic        neg_output_oe,
  input wire logic [3:0]  drive_section_enable,
  input wire logic [2:0]  signal_format_select
);
  // ----------------------------------------------------------------
  // Register shadows
  // ----------------------------------------------------------------
  logic [7:0] sh_q [8];
  logic [7:0] ctrl_q;
  logic       fast_sel;
  logic       byp;
  logic       sq;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_q   <= '{default: 8'h00};
      ctrl_q <= OCD_RST_CTRL;
    end else if (reg_write && reg_addr[11:3] == 9'h040) begin
      sh_q[reg_addr[2:0]] <= reg_wdata & ((reg_addr[2:0] == 3'h2) ? 8'hf1 : 8'hff);
    end else if (reg_write && reg_addr == OCD_OFS_CTRL) begin
      ctrl_q <= reg_wdata & 8'hc3;
    end
  end

  assign fast_sel = sh_q[2][6] ? fast_divider_two : fast_divider_one;
  // Bypass, nothing forcing the core low
  assign byp = sh_q[0][6:0] == 7'h00 && !sh_q[1][7] && sh_q[1][2:0] == 3'h1 && ctrl_q[7:6] == 2'b01;
  assign sq = sh_q[0][6:0] != 7'h00 && sh_q[1] == 8'h81 && ctrl_q == 8'h40 && !selected_reference;

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_drive_sections: assert property (
    drive_section_enable == (4'hf >> (2'h3 - $past(sh_q[1][5:4]))))
    else $error("drive sections wrong");
  a_format_copy: assert property (
    signal_format_select == $past(sh_q[1][2:0]))
    else $error("format copy wrong");
  a_global_float: assert property (
    (!ctrl_q[6]) [*2] |-> !pos_output_oe && !neg_output_oe)
    else $error("driven while disabled");
  a_format_off: assert property (
    (sh_q[1][2:0] == 3'h0) [*2] |-> !pos_output_oe && !neg_output_oe)
    else $error("driven in format off");
  a_neg_only: assert property (
    (sh_q[1][2:0] == 3'h5) [*2] |-> !pos_output_oe)
    else $error("positive pin driven");
  a_pos_only: assert property (
    (sh_q[1][2:0] == 3'h6) [*2] |-> !neg_output_oe)
    else $error("negative pin driven");
  a_stop_float: assert property (
    (ctrl_q[7] && ctrl_q[1:0] == 2'h0 && sh_q[0][6:0] != 7'h00 && sh_q[1][3]) [*3]
      |-> !pos_output_oe && !neg_output_oe)
    else $error("driven while stopped");
  a_squelch_hold: assert property (
    sq [*4] |-> !pos_output_pin && neg_output_pin)
    else $error("squelch levels wrong");
  a_bypass_follow: assert property (
    (byp && $stable(sh_q[2][6]) && $stable(sh_q[1][6])) [*3]
      |-> pos_output_pin == ($past(fast_sel, 2) ^ sh_q[1][6]))
    else $error("bypass pin wrong");
  a_status_gate: assert property (
    reg_read && reg_addr == OCD_OFS_STATUS && !sh_q[2][7] |=> reg_rdata[1:0] == 2'b00)
    else $error("status not gated");
  a_read_back: assert property (
    reg_read && reg_addr[11:3] == 9'h040 |=> reg_rdata == $past(sh_q[reg_addr[2:0]]))
    else $error("read back wrong");
endmodule : ocd_output_divider_properties

bind ocd_output_divider ocd_output_divider_properties i_props (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .fast_divider_one(fast_divider_one), .fast_divider_two(fast_divider_two),
  .selected_reference(selected_reference),
  .pos_output_pin(pos_output_pin), .pos_output_oe(pos_output_oe),
  .neg_output_pin(neg_output_pin), .neg_output_oe(neg_output_oe),
  .drive_section_enable(drive_section_enable), .signal_format_select(signal_format_select));
`default_nettype wire

//--- bench/testbench.sv
// Purpose: Self-checking bench for one output's clock divider block
// Assumes: Fast divider levels toggle every one and two clocks
// Notes:   Pin timing is counted in clock cycles, sampled at falling edges
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module testbench
  import ocd_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic        fast_divider_one = 1'b0;
  logic        fast_divider_two = 1'b0;
  logic        selected_reference = 1'b1;
  logic        phase_adjust_event = 1'b0;
  logic [7:0]  reg_rdata;
  logic        pos_output_pin, pos_output_oe, neg_output_pin, neg_output_oe;
  logic [3:0]  drive_section_enable;
  logic [2:0]  signal_format_select;
  int          errors = 0;
  int          n_checks = 0;
  int          cyc = 0;
  logic        ps = 1'b0;
  logic        pv = 1'b0;
  int          t0;
  int          th;

  ocd_output_divider i_ocd_output_divider (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .fast_divider_one(fast_divider_one), .fast_divider_two(fast_divider_two),
    .selected_reference(selected_reference), .phase_adjust_event(phase_adjust_event),
    .pos_output_pin(pos_output_pin), .pos_output_oe(pos_output_oe),
    .neg_output_pin(neg_output_pin), .neg_output_oe(neg_output_oe),
    .drive_section_enable(drive_section_enable), .signal_format_select(signal_format_select));

  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    fast_divider_one <= ~fast_divider_one;
    if (cyc[0]) begin
      fast_divider_two <= ~fast_divider_two;
    end
  end

  // ----------------------------------------------------------------
  // Access and measurement tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    `CHK(reg_rdata & m, e)
  endtask : rd

  // Bounded: a dead pin mismatches, never hangs
  task automatic lvl(input logic b);
    int n;
    n = 0;
    while ((((ps ? neg_output_pin : pos_output_pin) ^ pv) !== b) && n < 900) begin
      @(negedge clk);
      n++;
    end
  endtask : lvl

  task automatic rises(input int r);
    repeat (r) begin
      lvl(1'b0);
      lvl(1'b1);
    end
  endtask : rises

  // First period after a change may be short; skip it
  task automatic clk_chk(input logic s, input logic v, input int eh, input int ep);
    ps = s;
    pv = v;
    rises(2);
    t0 = cyc;
    lvl(1'b0);
    th = cyc;
    lvl(1'b1);
    `CHK(th - t0, eh)
    `CHK(cyc - t0, ep)
  endtask : clk_chk

  task automatic span(input int ep);
    ps = 1'b0;
    pv = 1'b0;
    rises(2);
    t0 = cyc;
    @(posedge clk);
    phase_adjust_event <= 1'b1;
    @(posedge clk);
    phase_adjust_event <= 1'b0;
    rises(2);
    `CHK(cyc - t0, ep)
  endtask : span

  task automatic test_done();
    if (errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    `CHK({pos_output_oe, neg_output_oe, drive_section_enable}, 6'h01)
    for (int a = 0; a < 11; a++) begin
      rd(OCD_OFS_CFG1 + 12'(a), (a == 8) ? 8'h60 : 8'h00, 8'hff);
    end
    for (int a = 0; a < 8; a++) begin
      wr(OCD_OFS_CFG1 + 12'(a), 8'h5a ^ 8'(a));
    end
    for (int a = 0; a < 8; a++) begin
      rd(OCD_OFS_CFG1 + 12'(a), (8'h5a ^ 8'(a)) & ((a == 2) ? 8'hf1 : 8'hff), 8'hff);
    end
    wr(12'h20a, 8'hff);
    rd(12'h20a, 8'h00, 8'hff);
    wr(OCD_OFS_CTRL, 8'h3c);
    rd(OCD_OFS_CTRL, 8'h20, 8'hff);
    for (int a = 0; a < 8; a++) begin
      wr(OCD_OFS_CFG1 + 12'(a), 8'h00);
    end
    wr(OCD_OFS_CTRL, 8'h40);
    for (int f = 0; f < 8; f++) begin
      for (int d = 0; d < 4; d++) begin
        wr(OCD_OFS_CFG2, {2'b00, 2'(d), 1'b0, 3'(f)});
        repeat (3) @(negedge clk);
        `CHK(drive_section_enable, 4'hf >> (3 - d))
        `CHK(signal_format_select, 3'(f))
        `CHK({pos_output_oe, neg_output_oe}, {f != 0 && f != 5, f != 0 && f != 6})
      end
    end
    wr(OCD_OFS_CFG2, 8'h01);
    wr(OCD_OFS_CTRL, 8'h00);
    repeat (3) @(negedge clk);
    `CHK({pos_output_oe, neg_output_oe}, 2'b00)
    wr(OCD_OFS_CTRL, 8'h40);
    clk_chk(1'b0, 1'b0, 1, 2);
    wr(OCD_OFS_LDIV0, 8'h03);
    wr(OCD_OFS_CFG3, 8'h50);
    clk_chk(1'b0, 1'b0, 2, 4);
    wr(OCD_OFS_CFG3, 8'h00);
    wr(OCD_OFS_CFG1, 8'h06);
    clk_chk(1'b0, 1'b0, 8, 14);
    wr(OCD_OFS_CFG3, 8'h10);
    clk_chk(1'b0, 1'b0, 28, 56);
    for (int p = 1; p < 4; p += 2) begin
      wr(OCD_OFS_DUTY, 8'(p));
      clk_chk(1'b0, 1'b0, 14 * p, 56);
    end
    wr(OCD_OFS_DUTY, 8'h01);
    wr(OCD_OFS_CFG2, 8'h41);
    clk_chk(1'b0, 1'b1, 14, 56);
    wr(OCD_OFS_DUTY, 8'h00);
    wr(OCD_OFS_CFG2, 8'h04);
    wr(OCD_OFS_CFG3, 8'h20);
    clk_chk(1'b0, 1'b0, 8, 14);
    clk_chk(1'b1, 1'b0, 28, 56);
    wr(OCD_OFS_CFG2, 8'h01);
    wr(OCD_OFS_CFG3, 8'h00);
    wr(OCD_OFS_PHASE, 8'h08);
    for (int e = 0; e < 2; e++) begin
      wr(OCD_OFS_CFG1, {1'(e), 7'h06});
      span(28 + 8 * e);
    end
    wr(OCD_OFS_CFG2, 8'h81);
    for (int m = 0; m < 3; m++) begin
      @(posedge clk);
      selected_reference <= 1'b1;
      wr(OCD_OFS_CTRL, 8'h40 | 8'(m));
      repeat (30) @(posedge clk);
      selected_reference <= 1'b0;
      repeat (30) @(negedge clk);
      `CHK({pos_output_pin, neg_output_pin}, {m == 1, m != 1})
    end
    @(posedge clk);
    selected_reference <= 1'b1;
    wr(OCD_OFS_CFG2, 8'h09);
    wr(OCD_OFS_CTRL, 8'hc0);
    repeat (30) @(negedge clk);
    `CHK({pos_output_oe, neg_output_oe}, 2'b00)
    rd(OCD_OFS_STATUS, 8'h04, 8'h04);
    wr(OCD_OFS_CTRL, 8'h40);
    repeat (30) @(negedge clk);
    `CHK({pos_output_oe, neg_output_oe}, 2'b11)
    wr(OCD_OFS_CFG3, 8'h90);
    repeat (60) @(negedge clk);
    rd(OCD_OFS_STATUS, 8'h02, 8'h02);
    wr(OCD_OFS_CFG3, 8'h10);
    rd(OCD_OFS_STATUS, 8'h00, 8'h03);
    test_done();
  end

  // Tests need a few thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    test_done();
  end
endmodule : testbench
`default_nettype wire
